// >>> rtl/ccd_regs.svh
// Offsets, flag positions, reset values and opcodes of the condition and operand decoder
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH
`define CCD_OFS_MASK 8'hfb
`define CCD_OFS_FLAGS 8'hfc
`define CCD_OFS_WGP 8'hfd
`define CCD_RST_MASK 8'h00
`define CCD_RST_FLAGS 8'h00
`define CCD_RST_WGP 8'h00
`define CCD_FLAG_C 7
`define CCD_FLAG_Z 6
`define CCD_FLAG_S 5
`define CCD_FLAG_V 4
`define CCD_FLAG_D 3
`define CCD_FLAG_H 2
`define CCD_MASK_EN 7
`define CCD_OPC_IEN 8'h9f
`define CCD_OPC_IDIS 8'h8f
`define CCD_OPC_PML 8'hc2
`define CCD_OPC_PMLI 8'hc3
`define CCD_OPC_LD_W_IW 8'he3
`define CCD_OPC_LD_IW_W 8'hf3
`define CCD_OPC_LD_R_R 8'he4
`define CCD_OPC_LD_R_IND 8'he5
`define CCD_OPC_LD_R_IMM 8'he6
`define CCD_OPC_LD_IND_IMM 8'he7
`define CCD_OPC_LD_IND_R 8'hf5
`define CCD_OPC_CALL_PAIR 8'hd4
`define CCD_OPC_JP_PAIR 8'h30
`define CCD_OPC_CALL_DA 8'hd6
`define CCD_NIB_JP 4'hd
`define CCD_NIB_JR 4'hb
`define CCD_NIB_ADD 4'h0
`define CCD_NIB_ADC 4'h1
`define CCD_SP_CALL_DEC 2'h2
`endif

// >>> rtl/ccd_pkg.sv
// Shared types of the condition and operand decoder
package ccd_pkg;
   typedef enum logic [3:0] {mode_none, mode_reg, mode_wreg, mode_ind, mode_ind_wreg, mode_ind_pair,
      mode_imm, mode_da, mode_ra} ccd_mode_t;
   typedef enum logic [3:0] {op_none, op_add, op_adc, op_ien, op_idis, op_pml, op_pmli, op_ld,
      op_call_da, op_call_pair, op_jp_pair, op_jp_cc, op_jr_cc} ccd_op_t;
endpackage

// >>> rtl/ccd_cond_eval.sv
// Branch condition evaluator over the status flags
`timescale 1ns/1ns
`default_nettype none
`include "ccd_regs.svh"

module ccd_cond_eval (
   // Condition field and flags
   input wire logic [3:0] cc,
   input wire logic [7:0] flags,
   // Verdict
   output logic taken
);
   wire c = flags[`CCD_FLAG_C];
   wire z = flags[`CCD_FLAG_Z];
   wire s = flags[`CCD_FLAG_S];
   wire v = flags[`CCD_FLAG_V];
   wire sv = s ^ v;
   logic base;

   // Low three bits pick the test; bit 3 inverts it, so each pair shares one term
   always_comb begin
      case (cc[2:0])
         3'h0: base = 1'b0;
         3'h1: base = sv;
         3'h2: base = z | sv;
         3'h3: base = c | z;
         3'h4: base = v;
         3'h5: base = s;
         3'h6: base = z;
         3'h7: base = c;
         default: base = 1'b0;
      endcase
   end

   assign taken = base ^ cc[3];
endmodule
`default_nettype wire

// >>> rtl/ccd_operand_dec.sv
// Opcode to operation kind and addressing form decoder
`timescale 1ns/1ns
`default_nettype none
`include "ccd_regs.svh"

module ccd_operand_dec (
   // Opcode
   input wire logic [7:0] opcode,
   // Decoded kind and forms
   output ccd_pkg::ccd_op_t op,
   output ccd_pkg::ccd_mode_t dst_mode,
   output ccd_pkg::ccd_mode_t src_mode
);
   wire [3:0] hi = opcode[7:4];
   wire [3:0] lo = opcode[3:0];
   wire add_row = (hi == `CCD_NIB_ADD) || (hi == `CCD_NIB_ADC);
   wire add_col = (lo >= 4'h2) && (lo <= 4'h7);

   // Add family forms by column
   function automatic ccd_pkg::ccd_mode_t add_dst(input logic [3:0] l);
      case (l)
         4'h2, 4'h3: add_dst = ccd_pkg::mode_wreg;
         4'h7: add_dst = ccd_pkg::mode_ind;
         default: add_dst = ccd_pkg::mode_reg;
      endcase
   endfunction

   function automatic ccd_pkg::ccd_mode_t add_src(input logic [3:0] l);
      case (l)
         4'h2: add_src = ccd_pkg::mode_wreg;
         4'h3: add_src = ccd_pkg::mode_ind_wreg;
         4'h4: add_src = ccd_pkg::mode_reg;
         4'h5: add_src = ccd_pkg::mode_ind;
         default: add_src = ccd_pkg::mode_imm;
      endcase
   endfunction

   // Exact opcodes first, then the column patterns of jumps and adds
   always_comb begin
      op = ccd_pkg::op_none;
      dst_mode = ccd_pkg::mode_none;
      src_mode = ccd_pkg::mode_none;
      case (opcode)
         `CCD_OPC_IEN: op = ccd_pkg::op_ien;
         `CCD_OPC_IDIS: op = ccd_pkg::op_idis;
         `CCD_OPC_PML: begin
            op = ccd_pkg::op_pml;
            dst_mode = ccd_pkg::mode_wreg;
            src_mode = ccd_pkg::mode_ind_pair;
         end
         `CCD_OPC_PMLI: begin
            op = ccd_pkg::op_pmli;
            dst_mode = ccd_pkg::mode_ind_wreg;
            src_mode = ccd_pkg::mode_ind_pair;
         end
         `CCD_OPC_LD_W_IW: begin
            op = ccd_pkg::op_ld;
            dst_mode = ccd_pkg::mode_wreg;
            src_mode = ccd_pkg::mode_ind_wreg;
         end
         `CCD_OPC_LD_IW_W: begin
            op = ccd_pkg::op_ld;
            dst_mode = ccd_pkg::mode_ind_wreg;
            src_mode = ccd_pkg::mode_wreg;
         end
         `CCD_OPC_LD_R_R, `CCD_OPC_LD_R_IND, `CCD_OPC_LD_R_IMM: begin
            op = ccd_pkg::op_ld;
            dst_mode = ccd_pkg::mode_reg;
            src_mode = (lo == 4'h4) ? ccd_pkg::mode_reg : (lo == 4'h5) ? ccd_pkg::mode_ind : ccd_pkg::mode_imm;
         end
         `CCD_OPC_LD_IND_IMM, `CCD_OPC_LD_IND_R: begin
            op = ccd_pkg::op_ld;
            dst_mode = ccd_pkg::mode_ind;
            src_mode = (lo == 4'h7) ? ccd_pkg::mode_imm : ccd_pkg::mode_reg;
         end
         `CCD_OPC_CALL_PAIR: begin
            op = ccd_pkg::op_call_pair;
            dst_mode = ccd_pkg::mode_ind_pair;
         end
         `CCD_OPC_JP_PAIR: begin
            op = ccd_pkg::op_jp_pair;
            dst_mode = ccd_pkg::mode_ind_pair;
         end
         `CCD_OPC_CALL_DA: begin
            op = ccd_pkg::op_call_da;
            dst_mode = ccd_pkg::mode_da;
         end
         default: begin
            if (lo == `CCD_NIB_JP) begin
               op = ccd_pkg::op_jp_cc;
               dst_mode = ccd_pkg::mode_da;
            end else if (lo == `CCD_NIB_JR) begin
               op = ccd_pkg::op_jr_cc;
               dst_mode = ccd_pkg::mode_ra;
            end else if (add_row && add_col) begin
               op = (hi == `CCD_NIB_ADD) ? ccd_pkg::op_add : ccd_pkg::op_adc;
               dst_mode = add_dst(lo);
               src_mode = add_src(lo);
            end
         end
      endcase
   end
endmodule
`default_nettype wire

// >>> rtl/ccd_top.sv
// Condition evaluation, operand decode, add unit and control registers of the core
`timescale 1ns/1ns
`default_nettype none
`include "ccd_regs.svh"

module ccd_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_q,
   // Instruction from the fetch path
   input wire logic instr_valid,
   input wire logic [7:0] opcode,
   input wire logic [7:0] oper_byte,
   input wire logic [7:0] dst_val,
   input wire logic [7:0] src_val,
   // Decode results
   output logic done_q,
   output ccd_pkg::ccd_op_t op_q,
   output ccd_pkg::ccd_mode_t dst_mode_q,
   output ccd_pkg::ccd_mode_t src_mode_q,
   output logic [7:0] dst_waddr_q,
   output logic [7:0] src_waddr_q,
   // Sequencer strobes
   output logic branch_q,
   output logic jump_pair_q,
   output logic push_pc_q,
   output logic [1:0] sp_dec_q,
   output logic pm_load_q,
   output logic pm_autoinc_q,
   // Add result
   output logic [7:0] result_q,
   output logic result_we_q,
   // Control registers
   output logic [7:0] interrupt_mask_q,
   output logic [7:0] status_flags_q,
   output logic [7:0] working_group_pointer_q
);
   // Register selects
   wire sel_mask = reg_addr == `CCD_OFS_MASK;
   wire sel_flags = reg_addr == `CCD_OFS_FLAGS;
   wire sel_wgp = reg_addr == `CCD_OFS_WGP;
   wire wr_mask = reg_wr && sel_mask;
   wire wr_flags = reg_wr && sel_flags;
   wire wr_wgp = reg_wr && sel_wgp;

   // Unmapped addresses read as zero
   wire [7:0] rd_mux = sel_mask ? interrupt_mask_q :
                       sel_flags ? status_flags_q :
                       sel_wgp ? working_group_pointer_q : 8'h00;

   // Decoder
   ccd_pkg::ccd_op_t dec_op;
   ccd_pkg::ccd_mode_t dec_dst;
   ccd_pkg::ccd_mode_t dec_src;

   ccd_operand_dec u_dec (
      .opcode(opcode),
      .op(dec_op),
      .dst_mode(dec_dst),
      .src_mode(dec_src)
   );

   // Condition sees the flag register as it stands, so the previous add is visible
   logic cond_true;

   ccd_cond_eval u_cond (
      .cc(opcode[7:4]),
      .flags(status_flags_q),
      .taken(cond_true)
   );

   // Operation classes; only add, enable and disable are qualified by the strobe here
   wire is_add = instr_valid && (dec_op == ccd_pkg::op_add || dec_op == ccd_pkg::op_adc);
   wire is_ien = instr_valid && dec_op == ccd_pkg::op_ien;
   wire is_idis = instr_valid && dec_op == ccd_pkg::op_idis;
   wire is_ccj = dec_op == ccd_pkg::op_jp_cc || dec_op == ccd_pkg::op_jr_cc;
   wire is_pair = dec_op == ccd_pkg::op_jp_pair || dec_op == ccd_pkg::op_call_pair;
   wire is_call = dec_op == ccd_pkg::op_call_da || dec_op == ccd_pkg::op_call_pair;
   wire is_pm = dec_op == ccd_pkg::op_pml || dec_op == ccd_pkg::op_pmli;

   // Adder; carry joins only for the carry-including variant
   wire carry_in = (dec_op == ccd_pkg::op_adc) && status_flags_q[`CCD_FLAG_C];
   wire [8:0] sum = {1'b0, dst_val} + {1'b0, src_val} + {8'h00, carry_in};
   wire [4:0] half = {1'b0, dst_val[3:0]} + {1'b0, src_val[3:0]} + {4'h0, carry_in};
   wire ovf = (dst_val[7] == src_val[7]) && (sum[7] != dst_val[7]);

   // Flag values the add produces
   logic [7:0] alu_flags;
   always_comb begin
      alu_flags = 8'h00;
      alu_flags[`CCD_FLAG_C] = sum[8];
      alu_flags[`CCD_FLAG_Z] = sum[7:0] == 8'h00;
      alu_flags[`CCD_FLAG_S] = sum[7];
      alu_flags[`CCD_FLAG_V] = ovf;
      alu_flags[`CCD_FLAG_H] = half[4];
   end

   // Per-flag policy: clear, set, update or keep
   logic [7:0] upd_mask;
   logic [7:0] clr_mask;
   logic [7:0] set_mask;
   always_comb begin
      upd_mask = 8'h00;
      clr_mask = 8'h00;
      set_mask = 8'h00;
      if (is_add) begin
         upd_mask[`CCD_FLAG_C] = 1'b1;
         upd_mask[`CCD_FLAG_Z] = 1'b1;
         upd_mask[`CCD_FLAG_S] = 1'b1;
         upd_mask[`CCD_FLAG_V] = 1'b1;
         upd_mask[`CCD_FLAG_H] = 1'b1;
         clr_mask[`CCD_FLAG_D] = 1'b1;
      end
   end

   // Instruction effect beats a software write in the same cycle
   wire [7:0] sw_flags = wr_flags ? reg_wdata : status_flags_q;
   logic [7:0] status_flags_d;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         assign status_flags_d[gi] = clr_mask[gi] ? 1'b0 :
                                     set_mask[gi] ? 1'b1 :
                                     upd_mask[gi] ? alu_flags[gi] : sw_flags[gi];
      end
   endgenerate

   // Interrupt mask: enable and disable touch bit 7 only
   logic [7:0] interrupt_mask_d;
   always_comb begin
      interrupt_mask_d = wr_mask ? reg_wdata : interrupt_mask_q;
      if (is_ien) begin
         interrupt_mask_d[`CCD_MASK_EN] = 1'b1;
      end else if (is_idis) begin
         interrupt_mask_d[`CCD_MASK_EN] = 1'b0;
      end
   end

   // Working register addresses come from the pointer's high nibble
   wire [7:0] dst_waddr_d = {working_group_pointer_q[7:4], oper_byte[7:4]};
   wire [7:0] src_waddr_d = {working_group_pointer_q[7:4], oper_byte[3:0]};

   // Control registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         status_flags_q <= `CCD_RST_FLAGS;
         interrupt_mask_q <= `CCD_RST_MASK;
         working_group_pointer_q <= `CCD_RST_WGP;
      end else begin
         status_flags_q <= status_flags_d;
         interrupt_mask_q <= interrupt_mask_d;
         working_group_pointer_q <= wr_wgp ? reg_wdata : working_group_pointer_q;
      end
   end

   // Read data stand for the single cycle after the strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata_q <= 8'h00;
      end else begin
         reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // Decode fields hold until the next instruction
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         op_q <= ccd_pkg::op_none;
         dst_mode_q <= ccd_pkg::mode_none;
         src_mode_q <= ccd_pkg::mode_none;
         dst_waddr_q <= 8'h00;
         src_waddr_q <= 8'h00;
         result_q <= 8'h00;
      end else if (instr_valid) begin
         op_q <= dec_op;
         dst_mode_q <= dec_dst;
         src_mode_q <= dec_src;
         dst_waddr_q <= dst_waddr_d;
         src_waddr_q <= src_waddr_d;
         result_q <= is_add ? sum[7:0] : result_q;
      end
   end

   // Strobes last one cycle after the instruction
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         done_q <= 1'b0;
         result_we_q <= 1'b0;
         branch_q <= 1'b0;
         jump_pair_q <= 1'b0;
      end else begin
         done_q <= instr_valid;
         result_we_q <= is_add;
         branch_q <= instr_valid && is_ccj && cond_true;
         jump_pair_q <= instr_valid && is_pair;
      end
   end

   // Call and program-memory strobes
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         push_pc_q <= 1'b0;
         sp_dec_q <= 2'h0;
         pm_load_q <= 1'b0;
         pm_autoinc_q <= 1'b0;
      end else begin
         push_pc_q <= instr_valid && is_call;
         sp_dec_q <= (instr_valid && is_call) ? `CCD_SP_CALL_DEC : 2'h0;
         pm_load_q <= instr_valid && is_pm;
         pm_autoinc_q <= instr_valid && dec_op == ccd_pkg::op_pmli;
      end
   end

   // Checks

   add_sum_a: assert property (
      @(posedge clock) disable iff (rst)
      is_add |=> result_we_q && result_q == $past(sum[7:0]))
      else $error("add result not stored");

   add_dclr_a: assert property (
      @(posedge clock) disable iff (rst)
      is_add |=> !status_flags_q[`CCD_FLAG_D] && status_flags_q[`CCD_FLAG_C] == $past(sum[8]))
      else $error("add flags wrong");

   adc_carry_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode[7:4] == 4'h1 && opcode[3:1] inside {3'h1, 3'h2, 3'h3} && status_flags_q[`CCD_FLAG_C]
      |=> result_q == $past(dst_val) + $past(src_val) + 8'h01)
      else $error("carry not added");

   irq_on_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'h9f |=> interrupt_mask_q[7])
      else $error("enable did not set mask bit");

   irq_off_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'h8f && !reg_wr |=> !interrupt_mask_q[7] && $stable(status_flags_q))
      else $error("disable wrong");

   pm_inc_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode[7:1] == 7'h61 |=> pm_load_q && pm_autoinc_q == $past(opcode[0]))
      else $error("program load strobes wrong");

   call_push_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'hd6 |=> push_pc_q && sp_dec_q == 2'h2 ##1 (!push_pc_q || $past(instr_valid)))
      else $error("call push wrong");

   signed_branch_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'h9b
      |=> branch_q == !($past(status_flags_q[`CCD_FLAG_S]) ^ $past(status_flags_q[`CCD_FLAG_V])))
      else $error("signed branch wrong");

   unsigned_branch_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'hbd
      |=> branch_q == ($past(status_flags_q[7:6]) == 2'h0))
      else $error("unsigned branch wrong");

   never_branch_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'h0b |=> !branch_q && done_q)
      else $error("never condition taken");

   flags_read_a: assert property (
      @(posedge clock) disable iff (rst)
      reg_rd && reg_addr == 8'hfc |=> reg_rdata_q == $past(status_flags_q))
      else $error("flag register read wrong");

   below_branch_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'h1b
      |=> branch_q == ($past(status_flags_q[`CCD_FLAG_S]) ^ $past(status_flags_q[`CCD_FLAG_V])))
      else $error("signed below branch wrong");

   carry_branch_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'h7d |=> branch_q == $past(status_flags_q[`CCD_FLAG_C]))
      else $error("carry branch wrong");

   nocarry_branch_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'hfb |=> branch_q == !$past(status_flags_q[`CCD_FLAG_C]))
      else $error("no carry branch wrong");

   atmost_branch_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'h3d |=> branch_q == ($past(status_flags_q[7:6]) != 2'h0))
      else $error("unsigned at most branch wrong");

   always_branch_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode[7:4] == 4'h8 && (opcode[3:0] == 4'hb || opcode[3:0] == 4'hd) |=> branch_q)
      else $error("always condition not taken");

   zero_branch_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'h6d |=> branch_q == $past(status_flags_q[`CCD_FLAG_Z]))
      else $error("zero branch wrong");

   nonjump_branch_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode[3:0] != 4'hb && opcode[3:0] != 4'hd |=> !branch_q)
      else $error("branch without conditional jump");

   irq_flags_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'h9f && !reg_wr |=> $stable(status_flags_q))
      else $error("enable changed flags");

   pm_modes_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'hc3
      |=> dst_mode_q == ccd_pkg::mode_ind_wreg && src_mode_q == ccd_pkg::mode_ind_pair)
      else $error("autoinc load forms wrong");

   wreg_addr_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'he3
      |=> src_mode_q == ccd_pkg::mode_ind_wreg && src_waddr_q[7:4] == $past(working_group_pointer_q[7:4]))
      else $error("working register load wrong");

   imm_load_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'he6 |=> op_q == ccd_pkg::op_ld && src_mode_q == ccd_pkg::mode_imm)
      else $error("immediate load wrong");

   pair_jump_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'h30 |=> jump_pair_q && !push_pc_q && op_q == ccd_pkg::op_jp_pair)
      else $error("pair jump wrong");

   pair_call_a: assert property (
      @(posedge clock) disable iff (rst)
      instr_valid && opcode == 8'hd4 |=> jump_pair_q && push_pc_q && sp_dec_q == 2'h2)
      else $error("pair call wrong");

endmodule
`default_nettype wire

// >>> tb/ccd_top_tb.sv
// Self-checking bench for the condition and operand decoder top
`timescale 1ns/1ns
`default_nettype none
`include "ccd_regs.svh"

module ccd_top_tb;
   logic clock, rst, reg_wr, reg_rd, instr_valid;
   logic [7:0] reg_addr, reg_wdata, opcode, oper_byte, dst_val, src_val, reg_rdata_q;
   logic done_q, branch_q, jump_pair_q, push_pc_q, pm_load_q, pm_autoinc_q, result_we_q;
   logic [1:0] sp_dec_q;
   logic [7:0] dst_waddr_q, src_waddr_q, result_q, interrupt_mask_q, status_flags_q, working_group_pointer_q;
   ccd_pkg::ccd_op_t op_q;
   ccd_pkg::ccd_mode_t dst_mode_q, src_mode_q;
   int error_cnt = 0;
   int n_compared = 0;
   logic [31:0] seed = 32'hc3f9a534;
   logic [7:0] f, v, w, o, a, b;
   logic [8:0] sum;

   ccd_top dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .instr_valid(instr_valid), .opcode(opcode),
      .oper_byte(oper_byte), .dst_val(dst_val), .src_val(src_val), .done_q(done_q), .op_q(op_q),
      .dst_mode_q(dst_mode_q), .src_mode_q(src_mode_q), .dst_waddr_q(dst_waddr_q), .src_waddr_q(src_waddr_q),
      .branch_q(branch_q), .jump_pair_q(jump_pair_q), .push_pc_q(push_pc_q), .sp_dec_q(sp_dec_q),
      .pm_load_q(pm_load_q), .pm_autoinc_q(pm_autoinc_q), .result_q(result_q), .result_we_q(result_we_q),
      .interrupt_mask_q(interrupt_mask_q), .status_flags_q(status_flags_q),
      .working_group_pointer_q(working_group_pointer_q));

   // Free-running 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Xorshift source, fixed start so every run repeats
   function logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   // Expected branch verdict; the top bit of the code inverts the base test
   function logic cond(input logic [3:0] cc, input logic [7:0] fl);
      logic c, z, s, ov, r;
      c = fl[`CCD_FLAG_C];
      z = fl[`CCD_FLAG_Z];
      s = fl[`CCD_FLAG_S];
      ov = fl[`CCD_FLAG_V];
      case (cc[2:0])
         3'h0: r = 1'b0;
         3'h1: r = s ^ ov;
         3'h2: r = z | (s ^ ov);
         3'h3: r = c | z;
         3'h4: r = ov;
         3'h5: r = s;
         3'h6: r = z;
         default: r = c;
      endcase
      return r ^ cc[3];
   endfunction

   // Expected flags after an add; bits 1:0 are not touched
   function logic [7:0] add_flags(input logic [7:0] fl, input logic [7:0] d, input logic [7:0] s, input logic ci);
      logic [8:0] r;
      logic [4:0] h;
      r = {1'b0, d} + {1'b0, s} + {8'h00, ci};
      h = {1'b0, d[3:0]} + {1'b0, s[3:0]} + {4'h0, ci};
      return {r[8], r[7:0] == 8'h00, r[7], (d[7] == s[7]) && (r[7] != d[7]), 1'b0, h[4], fl[1:0]};
   endfunction

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      if (error_cnt == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // Read data is looked at only in the cycle after the strobe
   task automatic rd(input logic [7:0] ad, output logic [7:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata_q;
   endtask

   // One instruction; results are checked just after the taking edge
   task automatic instr(input logic [7:0] opc, input logic [7:0] ob, input logic [7:0] d, input logic [7:0] s);
      @(posedge clock);
      instr_valid <= 1'b1;
      opcode <= opc;
      oper_byte <= ob;
      dst_val <= d;
      src_val <= s;
      @(posedge clock);
      instr_valid <= 1'b0;
      #1;
      chk("done", done_q, 1'b1);
   endtask

   // Decode of a non-add opcode with strobes worked out from the opcode
   task automatic dec(input logic [7:0] opc, input ccd_pkg::ccd_op_t k, input ccd_pkg::ccd_mode_t dm,
      input ccd_pkg::ccd_mode_t sm, input logic use_src);
      o = rnd();
      instr(opc, o, rnd(), rnd());
      chk("op", op_q, k);
      chk("dst_mode", dst_mode_q, dm);
      if (use_src)
         chk("src_mode", src_mode_q, sm);
      chk("dst_waddr", dst_waddr_q, {w[7:4], o[7:4]});
      chk("src_waddr", src_waddr_q, {w[7:4], o[3:0]});
      chk("pm_load", pm_load_q, opc == `CCD_OPC_PML || opc == `CCD_OPC_PMLI);
      chk("pm_autoinc", pm_autoinc_q, opc == `CCD_OPC_PMLI);
      chk("jump_pair", jump_pair_q, opc == `CCD_OPC_JP_PAIR || opc == `CCD_OPC_CALL_PAIR);
      chk("push_pc", push_pc_q, opc == `CCD_OPC_CALL_PAIR || opc == `CCD_OPC_CALL_DA);
      chk("sp_dec", sp_dec_q, (opc == `CCD_OPC_CALL_PAIR || opc == `CCD_OPC_CALL_DA) ? 2'h2 : 2'h0);
   endtask

   // A hung run is cut short and reported as failed
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      close_out();
   end

   initial begin
      rst = 1'b1;
      {reg_wr, reg_rd, instr_valid} = 3'b000;
      {reg_addr, reg_wdata, opcode, oper_byte, dst_val, src_val} = '0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      // Reset values, then read-write of each register and an unmapped place
      rd(`CCD_OFS_MASK, v);
      chk("mask_rst", v, `CCD_RST_MASK);
      rd(`CCD_OFS_FLAGS, v);
      chk("flags_rst", v, `CCD_RST_FLAGS);
      chk("op_rst", op_q, ccd_pkg::op_none);
      for (int i = 0; i < 3; i++) begin
         a = rnd();
         wr(`CCD_OFS_MASK + i[7:0], a);
         rd(`CCD_OFS_MASK + i[7:0], v);
         chk("reg_rw", v, a);
      end
      wr(8'hfe, 8'h5a);
      rd(8'hfe, v);
      chk("unmapped", v, 8'h00);
      // Every condition code against random flags, absolute and relative forms
      for (int i = 0; i < 64; i++) begin
         f = rnd();
         wr(`CCD_OFS_FLAGS, f);
         instr({i[3:0], i[4] ? `CCD_NIB_JR : `CCD_NIB_JP}, rnd(), rnd(), rnd());
         chk("branch", branch_q, cond(i[3:0], f));
         chk("op_cc", op_q, i[4] ? ccd_pkg::op_jr_cc : ccd_pkg::op_jp_cc);
      end
      // Random adds with and without carry, corner values among them
      for (int i = 0; i < 40; i++) begin
         f = rnd();
         a = (i == 0) ? 8'h01 : (i == 1) ? 8'h7f : rnd();
         b = (i == 0) ? 8'hff : (i == 1) ? 8'h01 : rnd();
         wr(`CCD_OFS_FLAGS, f);
         instr({i[0] ? `CCD_NIB_ADC : `CCD_NIB_ADD, 4'(i / 2 % 6 + 2)}, rnd(), a, b);
         sum = {1'b0, a} + {1'b0, b} + {8'h00, i[0] & f[`CCD_FLAG_C]};
         chk("result", result_q, sum[7:0]);
         chk("result_we", result_we_q, 1'b1);
         chk("op_add", op_q, i[0] ? ccd_pkg::op_adc : ccd_pkg::op_add);
         chk("add_flags", status_flags_q, add_flags(f, a, b, i[0] & f[`CCD_FLAG_C]));
      end
      // Add then a zero test on the very next cycle sees the new flags
      wr(`CCD_OFS_FLAGS, 8'h00);
      @(posedge clock);
      instr_valid <= 1'b1;
      opcode <= 8'h02;
      dst_val <= 8'h01;
      src_val <= 8'hff;
      @(posedge clock);
      opcode <= {4'h6, `CCD_NIB_JP};
      @(posedge clock);
      instr_valid <= 1'b0;
      #1;
      chk("branch_b2b", branch_q, 1'b1);
      // Interrupt enable and disable leave flags and other mask bits alone
      a = rnd();
      f = rnd();
      wr(`CCD_OFS_MASK, a);
      wr(`CCD_OFS_FLAGS, f);
      instr(`CCD_OPC_IEN, rnd(), rnd(), rnd());
      chk("mask_on", interrupt_mask_q, a | 8'h80);
      chk("flags_on", status_flags_q, f);
      instr(`CCD_OPC_IDIS, rnd(), rnd(), rnd());
      chk("mask_off", interrupt_mask_q, a & 8'h7f);
      chk("flags_off", status_flags_q, f);
      // Operand forms, with a random working group so addresses carry it
      w = rnd();
      wr(`CCD_OFS_WGP, w);
      dec(`CCD_OPC_PML, ccd_pkg::op_pml, ccd_pkg::mode_wreg, ccd_pkg::mode_ind_pair, 1'b1);
      dec(`CCD_OPC_PMLI, ccd_pkg::op_pmli, ccd_pkg::mode_ind_wreg, ccd_pkg::mode_ind_pair, 1'b1);
      dec(`CCD_OPC_LD_W_IW, ccd_pkg::op_ld, ccd_pkg::mode_wreg, ccd_pkg::mode_ind_wreg, 1'b1);
      dec(`CCD_OPC_LD_IW_W, ccd_pkg::op_ld, ccd_pkg::mode_ind_wreg, ccd_pkg::mode_wreg, 1'b1);
      dec(`CCD_OPC_LD_R_R, ccd_pkg::op_ld, ccd_pkg::mode_reg, ccd_pkg::mode_reg, 1'b1);
      dec(`CCD_OPC_LD_R_IND, ccd_pkg::op_ld, ccd_pkg::mode_reg, ccd_pkg::mode_ind, 1'b1);
      dec(`CCD_OPC_LD_R_IMM, ccd_pkg::op_ld, ccd_pkg::mode_reg, ccd_pkg::mode_imm, 1'b1);
      dec(`CCD_OPC_LD_IND_IMM, ccd_pkg::op_ld, ccd_pkg::mode_ind, ccd_pkg::mode_imm, 1'b1);
      dec(`CCD_OPC_LD_IND_R, ccd_pkg::op_ld, ccd_pkg::mode_ind, ccd_pkg::mode_reg, 1'b1);
      dec(`CCD_OPC_CALL_PAIR, ccd_pkg::op_call_pair, ccd_pkg::mode_ind_pair, ccd_pkg::mode_none, 1'b0);
      dec(`CCD_OPC_JP_PAIR, ccd_pkg::op_jp_pair, ccd_pkg::mode_ind_pair, ccd_pkg::mode_none, 1'b0);
      dec(`CCD_OPC_CALL_DA, ccd_pkg::op_call_da, ccd_pkg::mode_da, ccd_pkg::mode_none, 1'b0);
      // A second reset in mid-run clears the registers again
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      #1;
      chk("mask_rst2", interrupt_mask_q, `CCD_RST_MASK);
      chk("flags_rst2", status_flags_q, `CCD_RST_FLAGS);
      chk("wgp_rst2", working_group_pointer_q, `CCD_RST_WGP);
      close_out();
   end
endmodule
`default_nettype wire
